/* hw/can_msgbuf_defs.vh */
// Constants for the CAN message buffer block
// Contract
// RULE1 - Standard identifier is 11 bits, MSB first, smaller value wins bus.
// RULE2 - Ident byte 0 holds ID10..3; byte 1 holds ID2..0, remote, extended.
// RULE3 - Remote flag 0 data frame, 1 remote frame; sent or received.
// RULE4 - Extended flag 0 standard, 1 extended; sent or received.
// RULE5 - Each buffer has eight byte-wide payload registers.
// RULE6 - Byte count comes from the 4-bit length code, bits 3-0.
// RULE7 - Remote frames send the length code unchanged but zero data bytes.
// RULE8 - Length code 0 to 8 gives 0 to 8 bytes; software stays in range.
// RULE9 - Every non-empty transmit buffer joins selection just before start of frame.
// RULE10 - Lowest local priority value wins selection.
// RULE11 - On a tie of lowest priority the lower index wins.
// RULE12 - Software touches priority only while buffer empty and selected.
// RULE13 - With stamping on, timer value is written to active buffer after frame end.
// RULE14 - Software reads transmit stamp only after buffer is empty again.
// RULE15 - Stamp timer is free running on the bit clock, wraps silently.
// RULE16 - Stamp timer is cleared to zero during initialization mode.
// RULE17 - Stamp registers are read-only; writes have no effect.
// RULE18 - Empty flag set means free; software clears it, controller sets it.
// RULE19 - Each transmit buffer has an 8-bit local priority field.
// RULE20 - Software selects a free buffer via the select register window.
// RULE21 - Length codes above 8 are treated as eight bytes.
// RULE22 - Buffer contents are undefined after reset.
`ifndef CAN_MSGBUF_DEFS_VH
`define CAN_MSGBUF_DEFS_VH
`define NUM_TXBUF        3
`define OFS_IDENT0       5'h00
`define OFS_IDENT1       5'h01
`define OFS_IDENT2       5'h02
`define OFS_IDENT3       5'h03
`define OFS_PAYLOAD0     5'h04
`define OFS_PAYLOAD7     5'h0B
`define OFS_LENGTH       5'h0C
`define OFS_LOCAL_PRIORITY_FIELD         5'h0D
`define OFS_STAMP_HI     5'h0E
`define OFS_STAMP_LO     5'h0F
`define OFS_TXFLAG       5'h10
`define OFS_TXSEL        5'h11
`define OFS_CTRL         5'h12
`define OFS_RXSTAT       5'h13
`define CTRL_INIT_BIT    0
`define CTRL_STAMP_BIT   1
`define CTRL_RESET       8'h0001
`define IDENT1_REMOTE    4
`define IDENT1_EXT       3
`define MAX_BYTES        4'h8
`define RXBUF_INDEX      2'h3
`endif

/* hw/can_tx_arbiter.v */
// Local priority arbiter over pending transmit buffers
`timescale 1ns/1ns
`default_nettype none
module can_tx_arbiter (
    input  wire [2:0]  pending,
    input  wire [23:0] local_priority_field,
    output reg         found,
    output reg  [1:0]  winner
);
    reg [7:0] best;
    integer   i;
    always @* begin
        best   = 8'hFF;
        found  = 1'b0;
        winner = 2'h0;
        for (i = 0; i < 3; i = i + 1) begin
            // RULE10 lowest value wins; RULE11 strict less keeps lower index
            if (pending[i] && (!found || local_priority_field[i*8 +: 8] < best)) begin
                best   = local_priority_field[i*8 +: 8];
                found  = 1'b1;
                winner = i[1:0];
            end
        end
    end
endmodule // can_tx_arbiter
`default_nettype wire

/* hw/can_msgbuf.v */
// CAN message buffers: transmit triple buffer, receive buffer, stamp timer
`timescale 1ns/1ns
`default_nettype none
`include "can_msgbuf_defs.vh"
module can_msgbuf (
    input  wire        CLK_SYS,
    input  wire        RESETN,
    input  wire [4:0]  ADDR,
    input  wire [7:0]  WDATA,
    input  wire        WR,
    input  wire        RD,
    output reg  [7:0]  RDATA,
    input  wire        BIT_TICK,
    input  wire        SOF_REQ,
    output wire        TX_VALID,
    output reg  [1:0]  TX_INDEX,
    output reg  [31:0] TX_IDENT,
    output reg  [3:0]  TX_LENGTH_CODE,
    output reg  [3:0]  TX_BYTE_COUNT,
    output reg         TX_REMOTE,
    output reg         TX_EXTENDED,
    output reg  [63:0] TX_PAYLOAD,
    input  wire        TX_DONE,
    input  wire        RX_DONE,
    input  wire [31:0] RX_IDENT,
    input  wire [3:0]  RX_LENGTH_CODE,
    input  wire [63:0] RX_PAYLOAD,
    output wire [3:0]  RX_BYTE_COUNT,
    output wire [10:0] STD_IDENT
);
    // Four buffers: 0..2 transmit, 3 receive. Contents hold no reset value.
    reg  [7:0]  mem_q [0:63];
    reg  [7:0]  local_priority_field_q [0:2];
    reg  [15:0] stamp_q [0:3];
    reg  [2:0]  empty_q;
    reg  [1:0]  sel_q;
    reg  [7:0]  ctrl_q;
    reg  [15:0] timer_q;
    reg         busy_q;
    reg  [1:0]  active_q;
    reg         tick_s1_q;
    reg         tick_s2_q;
    reg         tick_s3_q;
    reg         rx_new_q;

    wire        found;
    wire [1:0]  winner;
    wire [23:0] local_priority_field_vec;
    wire        bit_edge;
    wire        init_mode;
    wire        stamp_en;
    wire [1:0]  win_buf;
    reg  [7:0]  rd_d;
    integer     k;

    function [3:0] byte_count;
        input [3:0] code;
        input       remote;
        begin
            // RULE7 remote sends none
            if (remote)
                byte_count = 4'h0;
            // RULE21 clamp to eight
            else if (code > `MAX_BYTES)
                byte_count = `MAX_BYTES;
            // RULE6 count from code
            else
                byte_count = code;
        end
    endfunction

    function [5:0] slot;
        input [1:0] buf_i;
        input [3:0] ofs;
        begin
            slot = {buf_i, ofs};
        end
    endfunction

    assign init_mode = ctrl_q[`CTRL_INIT_BIT];
    assign stamp_en  = ctrl_q[`CTRL_STAMP_BIT];
    assign local_priority_field_vec  = {local_priority_field_q[2], local_priority_field_q[1], local_priority_field_q[0]};
    assign bit_edge  = tick_s2_q & ~tick_s3_q;
    assign win_buf   = winner;

    can_tx_arbiter u_arb (
        .pending (~empty_q),
        .local_priority_field    (local_priority_field_vec),
        .found   (found),
        .winner  (winner)
    );

    assign TX_VALID = busy_q;
    // RULE6 receive count
    assign RX_BYTE_COUNT = byte_count(mem_q[slot(`RXBUF_INDEX, 4'hC)][3:0],
                                      mem_q[slot(`RXBUF_INDEX, 4'h1)][`IDENT1_REMOTE]);
    // RULE1 eleven bit identifier, ID10 first
    assign STD_IDENT = {mem_q[slot(active_q, 4'h0)], mem_q[slot(active_q, 4'h1)][7:5]};

    // Bit tick is from another domain, so two flops before use
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            tick_s1_q <= 1'b0;
            tick_s2_q <= 1'b0;
            tick_s3_q <= 1'b0;
        end else begin
            tick_s1_q <= BIT_TICK;
            tick_s2_q <= tick_s1_q;
            tick_s3_q <= tick_s2_q;
        end
    end

    // RULE15 free running, wraps
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            timer_q <= 16'h0000;
        end else if (init_mode) begin
            // RULE16 cleared in init
            timer_q <= 16'h0000;
        end else if (bit_edge) begin
            timer_q <= timer_q + 16'h0001;
        end
    end

    // Control, select, empty flags and arbitration state
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_q   <= `CTRL_RESET;
            sel_q    <= 2'h0;
            empty_q  <= 3'b111;
            busy_q   <= 1'b0;
            active_q <= 2'h0;
            rx_new_q <= 1'b0;
        end else begin
            if (WR && ADDR == `OFS_CTRL)
                ctrl_q <= WDATA;
            // RULE20 select window
            if (WR && ADDR == `OFS_TXSEL && WDATA[1:0] < 2'h3)
                sel_q <= WDATA[1:0];
            // RULE18 software clears empty by writing one
            if (WR && ADDR == `OFS_TXFLAG)
                empty_q <= empty_q & ~WDATA[2:0];
            // RULE9 selection at start of frame
            if (SOF_REQ && !busy_q && found && !init_mode) begin
                busy_q   <= 1'b1;
                active_q <= win_buf;
            end
            if (busy_q && TX_DONE) begin
                busy_q <= 1'b0;
                // RULE18 set wins over clear
                empty_q[active_q] <= 1'b1;
            end
            if (RX_DONE)
                rx_new_q <= 1'b1;
            else if (WR && ADDR == `OFS_RXSTAT && WDATA[0])
                rx_new_q <= 1'b0;
            if (init_mode) begin
                busy_q  <= 1'b0;
                empty_q <= 3'b111;
            end
        end
    end

    // Buffer storage writes; no reset so contents start undefined
    // RULE22 no initial value
    always @(posedge CLK_SYS) begin
        if (WR && ADDR < `OFS_LOCAL_PRIORITY_FIELD && empty_q[sel_q])
            mem_q[slot(sel_q, ADDR[3:0])] <= WDATA;
        // RULE12 priority only when empty
        // RULE19 eight-bit priority
        if (WR && ADDR == `OFS_LOCAL_PRIORITY_FIELD && empty_q[sel_q])
            local_priority_field_q[sel_q] <= WDATA;
        // RULE3 RULE4 received flags stored as received
        if (RX_DONE) begin
            for (k = 0; k < 4; k = k + 1)
                mem_q[slot(`RXBUF_INDEX, k[3:0])] <= RX_IDENT[31-8*k -: 8];
            for (k = 0; k < 8; k = k + 1)
                mem_q[slot(`RXBUF_INDEX, k[3:0] + 4'h4)] <= RX_PAYLOAD[63-8*k -: 8];
            mem_q[slot(`RXBUF_INDEX, 4'hC)] <= {4'h0, RX_LENGTH_CODE};
        end
        // RULE13 stamp at frame end
        if (stamp_en && RX_DONE)
            stamp_q[`RXBUF_INDEX] <= timer_q;
        if (stamp_en && busy_q && TX_DONE)
            stamp_q[active_q] <= timer_q;
    end

    // Frame fields of the active buffer, registered for the link engine
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            TX_INDEX       <= 2'h0;
            TX_IDENT       <= 32'h0000_0000;
            TX_LENGTH_CODE <= 4'h0;
            TX_BYTE_COUNT  <= 4'h0;
            TX_REMOTE      <= 1'b0;
            TX_EXTENDED    <= 1'b0;
            TX_PAYLOAD     <= 64'h0000_0000_0000_0000;
        end else begin
            TX_INDEX <= active_q;
            // RULE2 standard byte layout
            TX_IDENT <= {mem_q[slot(active_q, 4'h0)], mem_q[slot(active_q, 4'h1)],
                         mem_q[slot(active_q, 4'h2)], mem_q[slot(active_q, 4'h3)]};
            // RULE3 remote bit sent
            TX_REMOTE <= mem_q[slot(active_q, 4'h1)][`IDENT1_REMOTE];
            // RULE4 identifier type sent
            TX_EXTENDED <= mem_q[slot(active_q, 4'h1)][`IDENT1_EXT];
            // RULE7 code sent unchanged
            TX_LENGTH_CODE <= mem_q[slot(active_q, 4'hC)][3:0];
            // RULE8 RULE21 byte count
            TX_BYTE_COUNT <= byte_count(mem_q[slot(active_q, 4'hC)][3:0],
                                        mem_q[slot(active_q, 4'h1)][`IDENT1_REMOTE]);
            // RULE5 eight payload bytes
            for (k = 0; k < 8; k = k + 1)
                TX_PAYLOAD[63-8*k -: 8] <= mem_q[slot(active_q, k[3:0] + 4'h4)];
        end
    end

    // Read mux; receive buffer reached at offsets plus 0x20 is not mapped,
    // so buffer reads come from the selected transmit buffer.
    always @* begin
        rd_d = 8'h00;
        if (ADDR < `OFS_LOCAL_PRIORITY_FIELD)
            rd_d = mem_q[slot(sel_q, ADDR[3:0])];
        else if (ADDR == `OFS_LOCAL_PRIORITY_FIELD)
            rd_d = local_priority_field_q[sel_q];
        // RULE17 read-only stamp
        else if (ADDR == `OFS_STAMP_HI)
            rd_d = stamp_q[sel_q][15:8];
        else if (ADDR == `OFS_STAMP_LO)
            rd_d = stamp_q[sel_q][7:0];
        else if (ADDR == `OFS_TXFLAG)
            rd_d = {5'h00, empty_q};
        else if (ADDR == `OFS_TXSEL)
            rd_d = {6'h00, sel_q};
        else if (ADDR == `OFS_CTRL)
            rd_d = ctrl_q;
        else if (ADDR == `OFS_RXSTAT)
            rd_d = {6'h00, busy_q, rx_new_q};
    end

    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN)
            RDATA <= 8'h00;
        else if (RD)
            RDATA <= rd_d;
        else
            RDATA <= 8'h00;
    end
endmodule // can_msgbuf
`default_nettype wire

/* verif/can_msgbuf_monitor.sv */
// Checker on the CAN message buffer ports
`timescale 1ns/1ns
`default_nettype none
`include "can_msgbuf_defs.vh"
module can_msgbuf_monitor (
    input wire logic        CLK_SYS,
    input wire logic        RESETN,
    input wire logic [4:0]  ADDR,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [7:0]  RDATA,
    input wire logic        SOF_REQ,
    input wire logic        TX_VALID,
    input wire logic [1:0]  TX_INDEX,
    input wire logic [31:0] TX_IDENT,
    input wire logic [3:0]  TX_LENGTH_CODE,
    input wire logic [3:0]  TX_BYTE_COUNT,
    input wire logic        TX_REMOTE,
    input wire logic        TX_EXTENDED,
    input wire logic        TX_DONE,
    input wire logic        RX_DONE,
    input wire logic [3:0]  RX_LENGTH_CODE,
    input wire logic [3:0]  RX_BYTE_COUNT,
    input wire logic [10:0] STD_IDENT
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);
    logic [1:0] hist_q;
    logic       steady;
    // Fields trail the grant by a cycle, so judge them from the third cycle on
    always @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) hist_q <= 2'b00;
        else hist_q <= {hist_q[0], TX_VALID};
    end
    assign steady = TX_VALID && (hist_q == 2'b11);
    rd_idle_zero_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside read slot");
    grant_after_sof_a: assert property ($rose(TX_VALID) |-> $past(SOF_REQ))
        else $error("grant without start request");
    frame_holds_a: assert property (TX_VALID && !TX_DONE && !(WR && ADDR == `OFS_CTRL)
        |=> TX_VALID) else $error("frame dropped early");
    done_frees_a: assert property (TX_VALID && TX_DONE |=> !TX_VALID)
        else $error("frame held after done");
    byte_count_a: assert property (steady |-> TX_BYTE_COUNT == (TX_REMOTE ? 4'h0 :
        (TX_LENGTH_CODE > `MAX_BYTES ? `MAX_BYTES : TX_LENGTH_CODE))) else $error("bad byte count");
    ident_map_a: assert property (steady |-> STD_IDENT == TX_IDENT[31:21])
        else $error("identifier mapping wrong");
    flag_bits_a: assert property (steady |-> TX_REMOTE == TX_IDENT[20]
        && TX_EXTENDED == TX_IDENT[19]) else $error("frame flags wrong");
    index_stable_a: assert property (steady |-> $stable(TX_INDEX))
        else $error("winner changed mid frame");
    rx_count_a: assert property (RX_DONE |=> RX_BYTE_COUNT == ($past(RX_LENGTH_CODE) >
        `MAX_BYTES ? `MAX_BYTES : $past(RX_LENGTH_CODE))) else $error("bad receive count");
endmodule // can_msgbuf_monitor
bind can_msgbuf can_msgbuf_monitor i_mon (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR),
    .WR(WR), .RD(RD), .RDATA(RDATA), .SOF_REQ(SOF_REQ), .TX_VALID(TX_VALID), .TX_INDEX(TX_INDEX),
    .TX_IDENT(TX_IDENT), .TX_LENGTH_CODE(TX_LENGTH_CODE), .TX_BYTE_COUNT(TX_BYTE_COUNT),
    .TX_REMOTE(TX_REMOTE), .TX_EXTENDED(TX_EXTENDED), .TX_DONE(TX_DONE), .RX_DONE(RX_DONE),
    .RX_LENGTH_CODE(RX_LENGTH_CODE), .RX_BYTE_COUNT(RX_BYTE_COUNT), .STD_IDENT(STD_IDENT));
`default_nettype wire

/* verif/can_link_model.sv */
// Behavioural link engine standing for the CAN bus side
`timescale 1ns/1ns
`default_nettype none
module can_link_model (
    input  wire logic clk,
    input  wire logic go,
    input  wire logic slow,
    input  wire logic tx_valid,
    output var  logic sof_req,
    output var  logic tx_done,
    output wire logic bit_tick
);
    logic [2:0] div_q = 3'h0;
    int         n;
    always @(posedge clk) div_q <= div_q + 3'h1;
    assign bit_tick = div_q[2];
    initial begin
        sof_req = 1'b0;
        tx_done = 1'b0;
    end
    always begin
        @(posedge clk);
        if (go) begin
            sof_req <= 1'b1;
            @(posedge clk);
            sof_req <= 1'b0;
            for (n = 0; n < 4 && tx_valid !== 1'b1; n++) @(posedge clk);
            repeat (slow ? 40 : 6) @(posedge clk);
            tx_done <= tx_valid;
            @(posedge clk);
            tx_done <= 1'b0;
        end
    end
endmodule // can_link_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the CAN message buffers
`timescale 1ns/1ns
`default_nettype none
`include "can_msgbuf_defs.vh"
module tb_top;
    logic CLK_SYS = 1'b0, RESETN = 1'b0, WR = 1'b0, RD = 1'b0, RX_DONE = 1'b0;
    logic go = 1'b0, slow = 1'b0, SOF_REQ, TX_DONE, BIT_TICK, TX_VALID, TX_REMOTE, TX_EXTENDED;
    logic [4:0] ADDR = 5'h00;
    logic [7:0] WDATA = 8'h00, RDATA, v, s0, s1;
    logic [1:0] TX_INDEX;
    logic [31:0] TX_IDENT, RX_IDENT = 32'h0000_0000;
    logic [3:0] TX_LENGTH_CODE, TX_BYTE_COUNT, RX_LENGTH_CODE = 4'h0, RX_BYTE_COUNT;
    logic [63:0] TX_PAYLOAD, RX_PAYLOAD = 64'h0000_0000_0000_0000;
    logic [10:0] STD_IDENT;
    int fails = 0, compares = 0, cycles = 0, n;
    can_msgbuf i_dut (.CLK_SYS(CLK_SYS), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .BIT_TICK(BIT_TICK), .SOF_REQ(SOF_REQ), .TX_VALID(TX_VALID),
        .TX_INDEX(TX_INDEX), .TX_IDENT(TX_IDENT), .TX_LENGTH_CODE(TX_LENGTH_CODE),
        .TX_BYTE_COUNT(TX_BYTE_COUNT), .TX_REMOTE(TX_REMOTE), .TX_EXTENDED(TX_EXTENDED),
        .TX_PAYLOAD(TX_PAYLOAD), .TX_DONE(TX_DONE), .RX_DONE(RX_DONE), .RX_IDENT(RX_IDENT),
        .RX_LENGTH_CODE(RX_LENGTH_CODE), .RX_PAYLOAD(RX_PAYLOAD), .RX_BYTE_COUNT(RX_BYTE_COUNT),
        .STD_IDENT(STD_IDENT));
    can_link_model i_link (.clk(CLK_SYS), .go(go), .slow(slow), .tx_valid(TX_VALID),
        .sof_req(SOF_REQ), .tx_done(TX_DONE), .bit_tick(BIT_TICK));
    initial forever #50 CLK_SYS = ~CLK_SYS;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Strobe stays up between back-to-back writes; the next non-write step lowers it
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        ADDR <= a; WDATA <= d; WR <= 1'b1; RD <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        ADDR <= a; WR <= 1'b0; RD <= 1'b1;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        @(negedge CLK_SYS);
        d = RDATA;
        @(posedge CLK_SYS);
    endtask
    task automatic ld(input logic [1:0] b, input logic [10:0] id, input logic rem,
                      input logic [3:0] len, input logic [7:0] pr);
        wr(`OFS_TXSEL, {6'h00, b});
        wr(`OFS_IDENT0, id[10:3]);
        wr(`OFS_IDENT1, {id[2:0], rem, 4'h0});
        wr(`OFS_LENGTH, {4'h0, len});
        wr(`OFS_LOCAL_PRIORITY_FIELD, pr);
        rd(`OFS_LOCAL_PRIORITY_FIELD, v);
        chk("priority", pr, v);
        rd(`OFS_IDENT1, v);
        chk("ident byte one", {id[2:0], rem, 1'b0}, v[7:3]);
    endtask
    task automatic frame(input logic [1:0] ix, input logic [10:0] id, input logic rem,
                         input logic [3:0] lc, input logic [3:0] cnt);
        // A write strobe left high would keep clearing the empty flags
        WR <= 1'b0;
        go <= 1'b1;
        @(posedge CLK_SYS);
        go <= 1'b0;
        for (n = 0; n < 8 && TX_VALID !== 1'b1; n++) @(posedge CLK_SYS);
        repeat (2) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk("winner", ix, TX_INDEX);
        chk("identifier", id, STD_IDENT);
        chk("remote", rem, TX_REMOTE);
        chk("extended", 1'b0, TX_EXTENDED);
        chk("length code", lc, TX_LENGTH_CODE);
        chk("byte count", cnt, TX_BYTE_COUNT);
        for (n = 0; n < 60 && TX_VALID !== 1'b0; n++) @(posedge CLK_SYS);
        chk("frame end", 1'b0, TX_VALID);
    endtask
    task automatic rxchk(input logic [3:0] c, input logic [3:0] e);
        // Data frame: remote bit of ident byte one is clear
        WR <= 1'b0;
        RX_IDENT <= 32'h1224_5678; RX_LENGTH_CODE <= c; RX_DONE <= 1'b1;
        @(posedge CLK_SYS);
        RX_DONE <= 1'b0;
        @(negedge CLK_SYS);
        chk("receive count", e, RX_BYTE_COUNT);
        rd(`OFS_RXSTAT, v);
        chk("receive status", 8'h01, v);
    endtask
    task automatic final_report;
        $display("mismatches %0d comparisons %0d", fails, compares);
        if (fails == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Frames take well under a few hundred cycles each
    always @(posedge CLK_SYS) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            final_report;
        end
    end
    initial begin
        repeat (6) @(posedge CLK_SYS);
        RESETN <= 1'b1;
        rd(`OFS_TXFLAG, v);
        chk("empty flags", 8'h07, v);
        rd(`OFS_CTRL, v);
        chk("control", `CTRL_RESET, v);
        rd(5'h1F, v);
        chk("unmapped", 8'h00, v);
        wr(`OFS_CTRL, 8'h02);
        ld(2'h0, 11'h123, 1'b0, 4'h3, 8'h05);
        ld(2'h1, 11'h456, 1'b0, 4'hC, 8'h02);
        ld(2'h2, 11'h7FF, 1'b1, 4'h5, 8'h02);
        wr(`OFS_TXFLAG, 8'h07);
        frame(2'h1, 11'h456, 1'b0, 4'hC, 4'h8);
        slow <= 1'b1;
        frame(2'h2, 11'h7FF, 1'b1, 4'h5, 4'h0);
        slow <= 1'b0;
        frame(2'h0, 11'h123, 1'b0, 4'h3, 4'h3);
        rd(`OFS_TXFLAG, v);
        chk("flags after", 8'h07, v);
        wr(`OFS_TXSEL, 8'h00);
        rd(`OFS_STAMP_HI, s0);
        rd(`OFS_STAMP_LO, s1);
        chk("stamp taken", 1'b1, {s0, s1} != 16'h0000);
        wr(`OFS_STAMP_HI, 8'hFF);
        wr(`OFS_STAMP_LO, 8'hFF);
        rd(`OFS_STAMP_HI, v);
        chk("stamp high", s0, v);
        rd(`OFS_STAMP_LO, v);
        chk("stamp low", s1, v);
        rxchk(4'hF, 4'h8);
        rxchk(4'h6, 4'h6);
        final_report;
    end
endmodule // tb_top
`default_nettype wire
